/* rtl/mfgpio_pkg.sv */
package mfgpio_pkg;
  localparam int unsigned NUM_PINS = 4;
  // register indices as printed; byte address is four times the index
  localparam logic [15:0] PIN3_CONTROL_IDX = 16'h403A;
  localparam logic [15:0] PIN4_CONTROL_IDX = 16'h403B;
  localparam logic [15:0] PIN5_CONTROL_IDX = 16'h403C;
  localparam logic [15:0] PIN6_CONTROL_IDX = 16'h403D;
  localparam logic [15:0] IRQ_STATUS_IDX   = 16'h4050;
  localparam logic [15:0] IRQ_MASK_IDX     = 16'h4051;
  localparam logic [15:0] PIN_LEVEL_IDX    = 16'h4052;
  // field positions
  localparam int unsigned DIR_BIT      = 15;
  localparam int unsigned PULL_HI      = 14;
  localparam int unsigned PULL_LO      = 13;
  localparam int unsigned EDGE_BIT     = 12;
  localparam int unsigned DOMAIN_BIT   = 11;
  localparam int unsigned POL_BIT      = 10;
  localparam int unsigned OD_BIT       = 9;
  localparam int unsigned LEVEL_BIT    = 8;
  localparam int unsigned ENA_BIT      = 7;
  localparam int unsigned FN_HI        = 3;
  localparam logic [15:0] CTRL_WMASK   = 16'hFF8F;
  // reset values: input, pull-down, active high, disabled (pin 6 enabled)
  localparam logic [15:0] CTRL_RST     = 16'hA400;
  localparam logic [15:0] CTRL_RST_P6  = 16'hA480;
  localparam logic [1:0]  PULL_NONE    = 2'h0;
  localparam logic [1:0]  PULL_DOWN    = 2'h1;
  localparam logic [1:0]  PULL_UP      = 2'h2;
  // debounce lengths in microseconds, as cycles at 100 MHz
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned SHORT_DEB_US   = 1;
  localparam int unsigned LONG_DEB_US    = 40;
  localparam int unsigned SHORT_DEB_CYC  = SHORT_DEB_US * CLK_MHZ;
  localparam int unsigned LONG_DEB_CYC   = LONG_DEB_US * CLK_MHZ;

  typedef enum logic [3:0] {
    FN_IN_LONG = 4'h0, FN_IN = 4'h1, FN_PWR_ONOFF = 4'h2, FN_SLEEP_WAKE = 4'h3,
    FN_SLEEP_WAKE_L = 4'h4, FN_SLEEP = 4'h5, FN_PWR_ON = 4'h6, FN_WDOG = 4'h7,
    FN_VS1 = 4'h8, FN_VS2 = 4'h9, FN_HWEN1 = 4'hA, FN_HWEN2 = 4'hB,
    FN_HWCTL1 = 4'hC, FN_HWCTL2 = 4'hD, FN_HWCTL1_L = 4'hE, FN_HWCTL2_L = 4'hF
  } mfgpio_infn_e;

  // requests routed from input pins, one bit per source
  typedef struct packed {
    logic hwCtl2;
    logic hwCtl1;
    logic hwEn2;
    logic hwEn1;
    logic voltageScaleInputTwo;
    logic voltageScaleInputOne;
    logic watchdogReset;
    logic powerOn;
    logic sleepReq;
    logic sleepWake;
    logic powerOnOff;
  } mfgpio_req_s;

  // internal sources selectable on output pins
  typedef struct packed {
    logic auxReset;
    logic extPowerClk2m;
    logic converterPowerOk;
    logic systemSupplyGood;
    logic extPowerEn2;
    logic extPowerEn1;
    logic dvsDone2;
    logic dvsDone1;
    logic powerStateChange;
    logic sleepState;
    logic onState;
    logic osc32k;
  } mfgpio_src_s;
endpackage : mfgpio_pkg

/* rtl/mfgpio_top.sv */
`timescale 1ns/1ps
// Operation
// - pull field 14:13: 00 none, 01 pull-down (reset), 10 pull-up, 11 reserved
// - edge mode 0: single edge, rising if polarity 1, falling if 0
// - edge mode 1: interrupt on both edges regardless of polarity
// - pin 3 domain bit: 0 digital I/O supply, 1 always-on supply
// - pins 4 to 6 domain bit: 0 digital I/O supply, 1 system supply
// - polarity bit 10: 0 inverted active low, 1 active high (reset)
// - bit 9: 0 push-pull output (reset), 1 open-drain output
// - enable bit 7: 0 tri-states pin; resets 0 for pins 3-5, 1 for pin 6
// - direction bit 15: 1 input (reset), 0 output; codes 0/1 plain input
// - input codes 2-7 route to power, sleep, wake, power-on, watchdog
// - input codes 8-15 route to scaling, hw enable, hw control inputs
// - output codes 0-4: gpio level, 32k clock, on, sleep, state change
// - output codes 8-15: dvs done, ext enables, supply good, clock, reset
module mfgpio_top
  import mfgpio_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              clkEn,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [3:0]        pinIn,
  output logic [3:0]             pinOut,
  output logic [3:0]             pinOe,
  output logic [3:0]             pullUpEn,
  output logic [3:0]             pullDownEn,
  output logic                   pin3AlwaysOnDomain,
  output logic [2:0]             pinSystemDomain,
  input  wire mfgpio_src_s       srcIn,
  output mfgpio_req_s            reqOut,
  output logic                   irq
);

  function automatic logic [31:0] idx2addr(input logic [15:0] idx);
    idx2addr = {14'h0000, idx, 2'h0};
  endfunction : idx2addr

  function automatic logic isLongFn(input logic [3:0] fn);
    isLongFn = (fn == FN_IN_LONG) || (fn == FN_SLEEP_WAKE_L) ||
               (fn == FN_HWCTL1_L) || (fn == FN_HWCTL2_L);
  endfunction : isLongFn

  function automatic logic [12:0] debLimit(input logic [3:0] fn);
    debLimit = isLongFn(fn) ? 13'(LONG_DEB_CYC - 1) : 13'(SHORT_DEB_CYC - 1);
  endfunction : debLimit

  // a pin listens only while enabled and set as input
  function automatic logic isListening(input logic [15:0] ctrl);
    isListening = ctrl[ENA_BIT] && ctrl[DIR_BIT];
  endfunction : isListening

  function automatic logic isDriving(input logic [15:0] ctrl);
    isDriving = ctrl[ENA_BIT] && !ctrl[DIR_BIT];
  endfunction : isDriving

  // status and level are read-only, so writes there are refused
  function automatic logic isWritable(input logic [2:0] sel);
    isWritable = (sel < 3'h4) || (sel == 3'h5);
  endfunction : isWritable

  // decode returns 0..3 for pins, 4 status, 5 mask, 6 level, 7 unmapped
  function automatic logic [2:0] decode(input logic [31:0] a);
    if (a == idx2addr(PIN3_CONTROL_IDX)) decode = 3'h0;
    else if (a == idx2addr(PIN4_CONTROL_IDX)) decode = 3'h1;
    else if (a == idx2addr(PIN5_CONTROL_IDX)) decode = 3'h2;
    else if (a == idx2addr(PIN6_CONTROL_IDX)) decode = 3'h3;
    else if (a == idx2addr(IRQ_STATUS_IDX)) decode = 3'h4;
    else if (a == idx2addr(IRQ_MASK_IDX)) decode = 3'h5;
    else if (a == idx2addr(PIN_LEVEL_IDX)) decode = 3'h6;
    else decode = 3'h7;
  endfunction : decode

  logic [15:0] ctrl_r [NUM_PINS];
  logic [3:0]  irqStatus_r;
  logic [3:0]  irqMask_r;
  logic [3:0]  sync1_r, sync2_r, sync3_r;
  logic [3:0]  level_r;
  logic [12:0] debCnt_r [NUM_PINS];
  logic [3:0]  edgeHit;
  logic        statusRead;

  // write channel: address and data latched independently
  // ready is a one-cycle pulse, so a valid held by the master is taken once
  logic [31:0] awAddr_r;
  logic        awHave_r;
  logic [31:0] wData_r;
  logic [3:0]  wStrb_r;
  logic        wHave_r;
  logic [2:0]  wSel;

  assign wSel = decode(awAddr_r);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      awAddr_r      <= 32'h0000_0000;
      awHave_r      <= 1'b0;
      wData_r       <= 32'h0000_0000;
      wStrb_r       <= 4'h0;
      wHave_r       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else if (clkEn) begin
      s_axi_awready <= !awHave_r && !s_axi_awready && !s_axi_bvalid && s_axi_awvalid;
      s_axi_wready  <= !wHave_r && !s_axi_wready && !s_axi_bvalid && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awAddr_r <= s_axi_awaddr;
        awHave_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHave_r <= 1'b1;
      end
      if (awHave_r && wHave_r && !s_axi_bvalid) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= isWritable(wSel) ? 2'h0 : 2'h2;
        awHave_r     <= 1'b0;
        wHave_r      <= 1'b0;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic doWrite;
  assign doWrite = clkEn && awHave_r && wHave_r && !s_axi_bvalid;

  // control registers; reserved bits 6:4 stay zero, bit 8 holds the output level
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < NUM_PINS - 1; i++) begin
        ctrl_r[i] <= CTRL_RST;
      end
      ctrl_r[NUM_PINS-1] <= CTRL_RST_P6;
    end else if (doWrite && wSel < 3'h4) begin
      for (int b = 0; b < 2; b++) begin
        if (wStrb_r[b]) begin
          ctrl_r[wSel[1:0]][b*8 +: 8] <= wData_r[b*8 +: 8] & CTRL_WMASK[b*8 +: 8];
        end
      end
    end
  end

  // mask bit i lets the status bit of pin i+3 reach irq
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqMask_r <= 4'h0;
    end else if (doWrite && wSel == 3'h5 && wStrb_r[0]) begin
      irqMask_r <= wData_r[3:0];
    end
  end

  // read channel
  // a status read clears on the address handshake; the data keeps the old bits
  logic [2:0] rSel;
  assign rSel = decode(s_axi_araddr);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'h0;
    end else if (clkEn) begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= (rSel == 3'h7) ? 2'h2 : 2'h0;
        case (rSel)
          3'h0, 3'h1, 3'h2, 3'h3: s_axi_rdata <= {16'h0000, ctrl_r[rSel[1:0]]};
          3'h4: s_axi_rdata <= {28'h0000000, irqStatus_r};
          3'h5: s_axi_rdata <= {28'h0000000, irqMask_r};
          3'h6: s_axi_rdata <= {28'h0000000, level_r};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  assign statusRead = clkEn && s_axi_arvalid && s_axi_arready && rSel == 3'h4;

  // three-stage synchroniser; stage 1 feeds only stage 2
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
      sync3_r <= 4'h0;
    end else if (clkEn) begin
      sync1_r <= pinIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end

  // debounce: filtered level follows only after a stable run of the chosen length
  // any glitch restarts the count: latency is traded for noise immunity
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      level_r <= 4'h0;
      for (int i = 0; i < NUM_PINS; i++) begin
        debCnt_r[i] <= 13'h0000;
      end
    end else if (clkEn) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        if (sync2_r[i] != sync3_r[i] || sync3_r[i] == level_r[i]) begin
          debCnt_r[i] <= 13'h0000;
        end else if (debCnt_r[i] >= debLimit(ctrl_r[i][FN_HI:0])) begin
          level_r[i]  <= sync3_r[i];
          debCnt_r[i] <= 13'h0000;
        end else begin
          debCnt_r[i] <= debCnt_r[i] + 13'h0001;
        end
      end
    end
  end

  // edge qualification on the filtered level
  logic [3:0] levelPrev_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      levelPrev_r <= 4'h0;
    end else if (clkEn) begin
      levelPrev_r <= level_r;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      logic rise, fall;
      rise = level_r[i] && !levelPrev_r[i];
      fall = !level_r[i] && levelPrev_r[i];
      if (ctrl_r[i][EDGE_BIT]) begin
        edgeHit[i] = rise || fall;
      end else begin
        edgeHit[i] = ctrl_r[i][POL_BIT] ? rise : fall;
      end
      edgeHit[i] = edgeHit[i] && isListening(ctrl_r[i]);
    end
  end

  // set wins over the read-clear
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqStatus_r <= 4'h0;
    end else if (clkEn) begin
      irqStatus_r <= (statusRead ? 4'h0 : irqStatus_r) | edgeHit;
    end
  end

  // built from the stored status and the live edge hits, registered, so irq trails a read-clear by one cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else if (clkEn) begin
      irq <= |((irqStatus_r | edgeHit) & irqMask_r);
    end
  end

  // input routing: logical level after polarity, per pin
  // pins that share a code are ORed into one request
  mfgpio_req_s reqNxt;
  always_comb begin
    reqNxt = '0;
    for (int i = 0; i < NUM_PINS; i++) begin
      logic act;
      act = (level_r[i] == ctrl_r[i][POL_BIT])
            && isListening(ctrl_r[i]);
      case (ctrl_r[i][FN_HI:0])
        FN_PWR_ONOFF:                   reqNxt.powerOnOff = reqNxt.powerOnOff | act;
        FN_SLEEP_WAKE, FN_SLEEP_WAKE_L: reqNxt.sleepWake = reqNxt.sleepWake | act;
        FN_SLEEP:                       reqNxt.sleepReq = reqNxt.sleepReq | act;
        FN_PWR_ON:                      reqNxt.powerOn = reqNxt.powerOn | act;
        FN_WDOG:                        reqNxt.watchdogReset = reqNxt.watchdogReset | act;
        FN_VS1: reqNxt.voltageScaleInputOne = reqNxt.voltageScaleInputOne | act;
        FN_VS2: reqNxt.voltageScaleInputTwo = reqNxt.voltageScaleInputTwo | act;
        FN_HWEN1:                 reqNxt.hwEn1 = reqNxt.hwEn1 | act;
        FN_HWEN2:                 reqNxt.hwEn2 = reqNxt.hwEn2 | act;
        FN_HWCTL1, FN_HWCTL1_L:   reqNxt.hwCtl1 = reqNxt.hwCtl1 | act;
        FN_HWCTL2, FN_HWCTL2_L:   reqNxt.hwCtl2 = reqNxt.hwCtl2 | act;
        default: ; // codes 0 and 1 are plain inputs, seen only in the level and status registers
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reqOut <= '0;
    end else if (clkEn) begin
      reqOut <= reqNxt;
    end
  end

  // output selection; reserved codes 5-7 drive the inactive level
  logic [3:0] outNxt, oeNxt;
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      logic val;
      val = 1'b0;
      case (ctrl_r[i][FN_HI:0])
        4'h0: val = ctrl_r[i][LEVEL_BIT];
        4'h1: val = srcIn.osc32k;
        4'h2: val = srcIn.onState;
        4'h3: val = srcIn.sleepState;
        4'h4: val = srcIn.powerStateChange;
        4'h8: val = srcIn.dvsDone1;
        4'h9: val = srcIn.dvsDone2;
        4'hA: val = srcIn.extPowerEn1;
        4'hB: val = srcIn.extPowerEn2;
        4'hC: val = srcIn.systemSupplyGood;
        4'hD: val = srcIn.converterPowerOk;
        4'hE: val = srcIn.extPowerClk2m;
        4'hF: val = srcIn.auxReset;
        default: val = 1'b0;
      endcase
      val = ctrl_r[i][POL_BIT] ? val : !val;
      if (!isDriving(ctrl_r[i])) begin
        oeNxt[i]  = 1'b0;
        outNxt[i] = 1'b0;
      end else if (ctrl_r[i][OD_BIT]) begin
        oeNxt[i]  = !val;
        outNxt[i] = 1'b0;
      end else begin
        oeNxt[i]  = 1'b1;
        outNxt[i] = val;
      end
    end
  end

  // pin-facing outputs are registered, so source clocks reach the pad one cycle late
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinOut             <= 4'h0;
      pinOe              <= 4'h0;
      pullUpEn           <= 4'h0;
      pullDownEn         <= 4'h0;
      pin3AlwaysOnDomain <= 1'b0;
      pinSystemDomain    <= 3'h0;
    end else if (clkEn) begin
      pinOut <= outNxt;
      pinOe  <= oeNxt;
      for (int i = 0; i < NUM_PINS; i++) begin
        pullUpEn[i]   <= ctrl_r[i][PULL_HI:PULL_LO] == PULL_UP;
        pullDownEn[i] <= ctrl_r[i][PULL_HI:PULL_LO] == PULL_DOWN;
      end
      // domain outputs only steer pad supplies; no logic here reads them
      pin3AlwaysOnDomain <= ctrl_r[0][DOMAIN_BIT];
      for (int i = 1; i < NUM_PINS; i++) begin
        pinSystemDomain[i-1] <= ctrl_r[i][DOMAIN_BIT];
      end
    end
  end

endmodule : mfgpio_top

/* testbench/mfgpio_pin_env.sv */
`timescale 1ns/1ps
module mfgpio_pin_env
  import mfgpio_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic [3:0] pinOut,
  input  wire logic [3:0] pinOe,
  input  wire logic [3:0] pullUpEn,
  input  wire logic [3:0] pullDownEn,
  input  wire logic [3:0] extDrv,
  input  wire logic [3:0] extEn,
  output logic      [3:0] pinIn
);
  // a floating pad toggles every cycle so no stale level can pass for a valid one
  logic flt = 1'b0;
  always @(posedge ref_clk) flt <= ~flt;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (pinOe[i]) pinIn[i] = pinOut[i];
      else if (extEn[i]) pinIn[i] = extDrv[i];
      else if (pullUpEn[i]) pinIn[i] = 1'b1;
      else if (pullDownEn[i]) pinIn[i] = 1'b0;
      else pinIn[i] = flt;
    end
  end
endmodule : mfgpio_pin_env

/* testbench/mfgpio_top_checker.sv */
`timescale 1ns/1ps
module mfgpio_top_checker
  import mfgpio_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        clkEn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [3:0]  pinIn,
  input wire logic [3:0]  pinOe,
  input wire logic [3:0]  pullUpEn,
  input wire logic [3:0]  pullDownEn,
  input wire mfgpio_req_s reqOut,
  input wire logic        irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b || !clkEn);
  logic [3:0]  prevIn;
  logic [12:0] stab [4];
  logic        settled;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prevIn <= 4'h0;
      for (int i = 0; i < 4; i++) stab[i] <= 13'h0;
    end else begin
      prevIn <= pinIn;
      for (int i = 0; i < 4; i++) begin
        if (pinIn[i] != prevIn[i]) stab[i] <= 13'h0;
        else if (stab[i] != 13'h1FFF) stab[i] <= stab[i] + 13'h1;
      end
    end
  end
  // two cycles of slack for the phase of the debounce counter against this one
  always_comb begin
    settled = 1'b0;
    for (int i = 0; i < 4; i++) if (stab[i] >= 13'(SHORT_DEB_CYC - 2)) settled = 1'b1;
  end
  a_pull_exclusive: assert property ((pullUpEn & pullDownEn) == 4'h0)
    else $error("pull-up and pull-down enabled together");
  a_req_settled: assert property ($changed(reqOut) |-> settled)
    else $error("routed request changed without a debounced pin");
  a_irq_settled: assert property ($rose(irq) |-> settled)
    else $error("interrupt raised without a debounced pin");
  a_oe_after_reset: assert property ($rose(rst_b) |-> (pinOe == 4'h0) [*3])
    else $error("pin driven right after reset");
  a_irq_clears: assert property ($fell(irq) |-> $past(s_axi_rvalid) ||
    $past(s_axi_rvalid, 2) || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt dropped without a register access");
  a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("write address ready held");
  a_w_pulse: assert property (s_axi_wready |=> !s_axi_wready)
    else $error("write data ready held");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
endmodule : mfgpio_top_checker

bind mfgpio_top mfgpio_top_checker chk (.ref_clk, .rst_b, .clkEn, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .pinIn, .pinOe, .pullUpEn, .pullDownEn, .reqOut, .irq);

/* testbench/tb_mfgpio_top.sv */
`timescale 1ns/1ps
module tb_mfgpio_top;
  import mfgpio_pkg::*;
  logic        ref_clk, rst_b, clkEn, pin3AlwaysOnDomain, irq;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb, pinIn, pinOut, pinOe, pullUpEn, pullDownEn, extDrv, extEn;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [2:0]  pinSystemDomain;
  mfgpio_src_s srcIn;
  mfgpio_req_s reqOut;
  int          miscompares = 0, compares = 0, cycles = 0, n, b;
  logic [11:0] pat;
  logic        e, lg;
  logic [15:0] oc [6] = '{16'h2180, 16'h2080, 16'h2780, 16'h2680, 16'h2500, 16'hA580};
  logic [1:0]  oe [6] = '{2'h2, 2'h3, 2'h0, 2'h2, 2'h0, 2'h0};

  mfgpio_top dut (.*);
  mfgpio_pin_env env (.*);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // the long-debounce codes dominate the run: three codes, two 4000-cycle debounces each
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      give_verdict();
    end
  end

  function automatic logic [31:0] ra(input logic [15:0] idx);
    ra = {14'h0, idx, 2'b00};
  endfunction : ra
  task automatic give_verdict();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic wait_sig(input int bit_i, input logic v, input int lim, output int k);
    logic [11:0] s;
    k = 0;
    s = {irq, reqOut};
    while (s[bit_i] !== v && k < lim) begin
      @(posedge ref_clk);
      k++;
      s = {irq, reqOut};
    end
  endtask : wait_sig
  // edges are taken on the filtered level, so a polarity change sets no status; stale status is flushed first
  task automatic cfg5(input logic [31:0] v);
    wr(ra(PIN5_CONTROL_IDX), v, r);
    repeat (4) @(posedge ref_clk);
    rd(ra(IRQ_STATUS_IDX), d, r);
  endtask : cfg5
  task automatic pin5_edge(input logic lvl, input logic eIrq, input logic eStat);
    extDrv[2] <= lvl;
    // irq trails a read-clear by one cycle, so let it settle first
    @(posedge ref_clk);
    wait_sig(11, 1'b1, 300, n);
    check(n < 300, eIrq);
    rd(ra(IRQ_STATUS_IDX), d, r);
    check(d, eStat ? 32'h4 : 32'h0);
  endtask : pin5_edge

  initial begin
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid, s_axi_wvalid} = '0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    clkEn = 1'b1;
    rst_b = 1'b0;
    srcIn = '0;
    extEn = 4'hC;
    extDrv = 4'h0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ra(PIN3_CONTROL_IDX + 16'(i)), d, r);
      check(d, (i == 3) ? 32'h0000A480 : 32'h0000A400);
    end
    rd(32'h0000_0000, d, r);
    check(r, 2'h2);
    wr(ra(IRQ_STATUS_IDX), 32'h0, r);
    check(r, 2'h2);
    for (int i = 0; i < 4; i++) begin
      wr(ra(PIN3_CONTROL_IDX), 32'h8400 | (i << 13), r);
      repeat (2) @(posedge ref_clk);
      check({pullUpEn[0], pullDownEn[0]}, {i == 2, i == 1});
    end
    wr(ra(PIN3_CONTROL_IDX), 32'hAC00, r);
    wr(ra(PIN4_CONTROL_IDX), 32'hAC00, r);
    repeat (2) @(posedge ref_clk);
    check({pin3AlwaysOnDomain, pinSystemDomain}, 4'h9);
    for (int c = 0; c < 16; c++) begin
      wr(ra(PIN4_CONTROL_IDX), 32'h2580 | c, r);
      for (int p = 0; p < 2; p++) begin
        pat = p ? 12'h5A3 : 12'hA5C;
        srcIn <= pat;
        repeat (2) @(posedge ref_clk);
        e = (c == 0) ? 1'b1 : (c < 5) ? pat[c-1] : (c < 8) ? 1'b0 : pat[c-4];
        check({pinOe[1], pinOut[1]}, {1'b1, e});
      end
    end
    // clock enable low must freeze the registered pin drive
    wr(ra(PIN4_CONTROL_IDX), 32'h2581, r);
    srcIn <= 12'h000;
    repeat (2) @(posedge ref_clk);
    clkEn <= 1'b0;
    srcIn <= 12'h001;
    repeat (4) @(posedge ref_clk);
    check(pinOut[1], 1'b0);
    clkEn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check(pinOut[1], 1'b1);
    for (int i = 0; i < 6; i++) begin
      wr(ra(PIN4_CONTROL_IDX), {16'h0, oc[i]}, r);
      repeat (2) @(posedge ref_clk);
      check({pinOe[1], pinOut[1] & (i < 4)}, oe[i]);
    end
    wr(ra(IRQ_MASK_IDX), 32'h4, r);
    rd(ra(IRQ_MASK_IDX), d, r);
    check(d, 32'h4);
    cfg5(32'hA481);
    pin5_edge(1'b1, 1'b1, 1'b1);
    rd(ra(IRQ_STATUS_IDX), d, r);
    check(d, 32'h0);
    pin5_edge(1'b0, 1'b0, 1'b0);
    cfg5(32'hB481);
    pin5_edge(1'b1, 1'b1, 1'b1);
    pin5_edge(1'b0, 1'b1, 1'b1);
    cfg5(32'hA081);
    pin5_edge(1'b1, 1'b0, 1'b0);
    pin5_edge(1'b0, 1'b1, 1'b1);
    wr(ra(IRQ_MASK_IDX), 32'h0, r);
    cfg5(32'hB481);
    pin5_edge(1'b1, 1'b0, 1'b1);
    cfg5(32'hB401);
    pin5_edge(1'b0, 1'b0, 1'b0);
    for (int c = 2; c < 16; c++) begin
      b = (c < 4) ? c - 2 : (c == 4) ? 1 : (c < 14) ? c - 3 : c - 5;
      lg = (c == 4) || (c > 13);
      wr(ra(PIN6_CONTROL_IDX), 32'hA480 | c, r);
      extDrv[3] <= 1'b1;
      wait_sig(b, 1'b1, 6000, n);
      check({n >= 200, n < 6000}, {lg, 1'b1});
      check(32'(reqOut), 32'h1 << b);
      rd(ra(PIN_LEVEL_IDX), d, r);
      check(d, 32'h8);
      extDrv[3] <= 1'b0;
      wait_sig(b, 1'b0, 6000, n);
    end
    give_verdict();
  end
endmodule : tb_mfgpio_top
